/* File: pkg/cmc_consts.svh */
// register offsets, field positions, reset values and timing counts of the mode control block
`ifndef CMC_CONSTS_SVH
`define CMC_CONSTS_SVH
// ----------------------------------------------------------------
// register indexes (byte address is four times the index)
// ----------------------------------------------------------------
`define CMC_IDX_CTL0 2'h0
`define CMC_IDX_CTL1 2'h1
`define CMC_IDX_AUX 2'h2
`define CMC_IDX_TSTAMP 2'h3
// ----------------------------------------------------------------
// control register zero fields
// ----------------------------------------------------------------
`define CMC_C0_RECEIVED_FRAME_FLAG 7
`define CMC_C0_RECEIVER_ACTIVE 6
`define CMC_C0_STOPWAIT 5
`define CMC_C0_SYNC 4
`define CMC_C0_TIME 3
`define CMC_C0_WAKEUP_ENABLE 2
`define CMC_C0_SLEEP_REQUEST 1
`define CMC_C0_INIT_REQUEST 0
`define CMC_CTL0_RESET 8'h01
// ----------------------------------------------------------------
// control register one fields
// ----------------------------------------------------------------
`define CMC_C1_ENABLE 7
`define CMC_C1_CLOCK_SOURCE_SELECT 6
`define CMC_C1_LOOP 5
`define CMC_C1_LISTEN 4
`define CMC_C1_BUSOFF_RECOVERY_MODE 3
`define CMC_C1_WAKEUP_FILTER_MODE 2
`define CMC_C1_SLEEP_ACKNOWLEDGE 1
`define CMC_C1_INIT_ACKNOWLEDGE 0
`define CMC_CTL1_RESET 8'h11
// ----------------------------------------------------------------
// auxiliary register fields
// ----------------------------------------------------------------
`define CMC_AUX_RECOVER 0
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CMC_MCLK_PERIOD_NS 4
`define CMC_WUP_FILTER_NS 2000
`define CMC_WUP_FILTER_CYC ((`CMC_WUP_FILTER_NS + `CMC_MCLK_PERIOD_NS - 1) / `CMC_MCLK_PERIOD_NS)
`define CMC_IDLE_RUN_BITS 11
`define CMC_BUSOFF_RUNS 128
`endif

/* File: pkg/cmc_pkg.sv */
// types shared by the mode control block
`default_nettype none
package cmc_pkg;
  // mode bits handed to the protocol engine
  typedef struct packed {
    logic module_enable;
    logic clock_source_select;
    logic loopback_self_test;
    logic listen_only;
    logic busoff_recovery_mode;
    logic wakeup_filter_mode;
  } cmc_mode_t;
  // timestamp written into a buffer
  typedef struct packed {
    logic        write;
    logic [15:0] value;
  } cmc_stamp_t;
  // wakeup filter phase
  typedef enum logic [0:0] {
    CMC_WUP_IDLE = 1'b0,
    CMC_WUP_DOM  = 1'b1
  } cmc_wup_state_t;
endpackage
`default_nettype wire

/* File: hw/cmc_sync.sv */
// two flip-flop synchroniser for asynchronous levels
`timescale 1ns/1ns
`default_nettype none
module cmc_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '1
) (
  input wire logic mclk,              // module clock
  input wire logic rst,               // synchronous reset
  input wire logic ce,                // clock enable
  input wire logic [WIDTH-1:0] d,     // asynchronous level
  output logic [WIDTH-1:0] q          // synchronised level
);
  logic [WIDTH-1:0] meta;
  // first stage feeds only the second
  always_ff @(posedge mclk) begin
    if (rst) begin
      meta <= INIT;
      q <= INIT;
    end else if (ce) begin
      meta <= d;
      q <= meta;
    end
  end
endmodule
`default_nettype wire

/* File: hw/cmc_idle_counter.sv */
// counts runs of consecutive recessive bits until a target number of runs is seen
`timescale 1ns/1ns
`default_nettype none
`include "cmc_consts.svh"
module cmc_idle_counter #(
  parameter int RUN_BITS = `CMC_IDLE_RUN_BITS
) (
  input wire logic mclk,              // module clock
  input wire logic rst,               // synchronous reset
  input wire logic ce,                // clock enable
  input wire logic clear,             // restart counting
  input wire logic bit_tick,          // one pulse per bit time
  input wire logic rx_bit,            // sampled bus level, 1 recessive
  input wire logic [7:0] target,      // number of runs needed
  output logic done                   // target reached, held until clear
);
  logic [3:0] run;
  logic [7:0] runs;
  wire run_full = (run == 4'(RUN_BITS - 1));
  wire run_end = bit_tick && rx_bit && run_full;
  // a dominant bit restarts the current run
  always_ff @(posedge mclk) begin
    if (rst || (ce && clear)) begin
      run <= 4'h0;
      runs <= 8'h00;
      done <= 1'b0;
    end else if (ce && bit_tick && !done) begin
      if (!rx_bit) begin
        run <= 4'h0;
      end else if (run_full) begin
        run <= 4'h0;
        runs <= runs + 8'h01;
        done <= ((runs + 8'h01) >= target);
      end else begin
        run <= run + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: hw/cmc_mode_control.sv */
// mode, handshake and timestamp control of a CAN controller with an Avalon-MM register slave
`timescale 1ns/1ns
`default_nettype none
`include "cmc_consts.svh"
// How it works
// - received-frame flag sets on any valid received frame outside loopback, cleared by writing one
// - receiver-active bit reads one while receiving, zero when transmitting or idle
// - stop-in-wait gates interface clocks in wait and forces transmit recessive in wait; stop always forces it recessive
// - read-only synchronized bit, set and cleared by the block itself
// - timer enable runs a 16-bit bit-rate counter stamping each frame
// - stamp is written at end of frame; no receive stamp in loopback
// - counter clears when disabled; timer enable held low in initialization
// - wakeup enable lets bus traffic end sleep; configure it before sleeping
// - sleep granted only when not receiving and transmit buffers empty
// - sleep request refused while wakeup flag set; wakeup clears request and ack
// - initialization request aborts traffic, drops sync, then acknowledge sets
// - initialization holds control zero at reset except wakeup, sleep, init bits
// - control one writable only while init request and acknowledge are both one
// - restart after 11 recessive bits, or 128 such runs if bus-off starts before the first run after init or recovery ends
// - transmit pin forced recessive at once when initialization is requested
// - module enable written once in normal mode, freely in special, only in init
// - clock source bit picks oscillator at zero, bus clock at one
// - loopback feeds transmitter to receiver, ignores receive pin, transmit recessive
// - listen-only receives but sends no acknowledge, error frame or message
// - bus-off recovery automatic or on request; wake mode picks filtered wakeup
module cmc_mode_control #(
  parameter int WUP_FILTER_CYC = `CMC_WUP_FILTER_CYC
) (
  input wire logic mclk,                      // 250 MHz module clock
  input wire logic rst,                       // synchronous reset, active high
  input wire logic ce,                        // clock enable, freezes state when low
  input wire logic [3:0] avs_address,         // byte address
  input wire logic avs_read,                  // read request
  input wire logic avs_write,                 // write request
  input wire logic [31:0] avs_writedata,      // write data
  input wire logic [3:0] avs_byteenable,      // byte lanes
  output logic [31:0] avs_readdata,           // read data
  output logic avs_waitrequest,               // high until the transfer is taken
  input wire logic bus_receive_pin,           // bus level from transceiver
  output logic bus_transmit_pin,              // bus drive, 1 recessive
  input wire logic eng_tx_bit,                // transmitter bit stream
  output logic eng_rx_bit,                    // bit stream into receiver
  input wire logic bit_tick,                  // one pulse per bit time
  input wire logic rx_active_in,              // receiver front end busy
  input wire logic tx_buffers_empty,          // no transmit buffer pending
  input wire logic rx_eof_valid,              // end of a valid received frame
  input wire logic tx_eof_valid,              // end of a valid transmitted frame
  input wire logic busoff_in,                 // engine is bus-off
  input wire logic wakeup_int_flag,           // wakeup flag in the flag register
  input wire logic cpu_wait,                  // cpu in wait mode
  input wire logic cpu_stop,                  // cpu in stop mode
  input wire logic special_mode,              // special system mode
  output cmc_pkg::cmc_mode_t mode,            // mode bits to the engine
  output cmc_pkg::cmc_stamp_t stamp,          // timestamp to the active buffer
  output logic engine_abort,                  // abort traffic, hold engine flags reset
  output logic bus_synchronized,              // engine may take part on the bus
  output logic busoff_recover,                // pulse, leave bus-off
  output logic wakeup_event,                  // pulse, bus activity ended sleep
  output logic iface_clock_stop               // gate interface clocks
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic received_frame_flag;
  logic receiver_active;
  logic stop_in_wait;
  logic time_en;
  logic wakeup_enable;
  logic sleep_request;
  logic init_request;
  logic sleep_acknowledge;
  logic init_acknowledge;
  logic enable_written;
  logic recover_req;
  logic [15:0] ts_count;
  logic [$clog2(WUP_FILTER_CYC + 1)-1:0] wup_cnt;
  cmc_pkg::cmc_wup_state_t wup_state;
  logic rx_s;
  logic idle_done;

  // ----------------------------------------------------------------
  // pin synchroniser and idle run counter
  // ----------------------------------------------------------------
  cmc_sync #(.WIDTH(1), .INIT(1'b1)) u_rx_sync (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .d(bus_receive_pin),
    .q(rx_s)
  );

  wire idle_clear = init_request || busoff_recover;
  wire [7:0] idle_target = busoff_in ? 8'(`CMC_BUSOFF_RUNS) : 8'h01;
  cmc_idle_counter #(.RUN_BITS(`CMC_IDLE_RUN_BITS)) u_idle (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .clear(idle_clear),
    .bit_tick(bit_tick),
    .rx_bit(rx_s),
    .target(idle_target),
    .done(idle_done)
  );

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire [1:0] idx = avs_address[3:2];
  wire taken = ce && (avs_read || avs_write) && !avs_waitrequest;
  wire wr_lane = taken && avs_write && avs_byteenable[0];
  wire [7:0] wd = avs_writedata[7:0];
  wire wr_ctl0 = wr_lane && (idx == `CMC_IDX_CTL0);
  wire wr_ctl1 = wr_lane && (idx == `CMC_IDX_CTL1);
  wire wr_aux = wr_lane && (idx == `CMC_IDX_AUX);
  wire init_mode = init_request && init_acknowledge;
  wire run_mode = !init_request && !init_acknowledge;
  wire wr_ctl0_run = wr_ctl0 && run_mode;
  wire wr_ctl1_init = wr_ctl1 && init_mode;
  wire asleep = sleep_request && sleep_acknowledge;
  wire bus_idle = !rx_active_in && tx_buffers_empty;
  wire dominant = !rx_s;
  wire wup_filtered = (wup_state == cmc_pkg::CMC_WUP_DOM) && dominant
                      && (32'(wup_cnt) >= WUP_FILTER_CYC - 1);
  wire wake = ce && asleep && wakeup_enable && (mode.wakeup_filter_mode ? wup_filtered : dominant);
  wire force_recessive = init_request || mode.loopback_self_test || mode.listen_only
                         || (cpu_wait && stop_in_wait) || cpu_stop || asleep || !mode.module_enable;
  wire [7:0] ctl0_rd = {received_frame_flag, receiver_active, stop_in_wait, bus_synchronized,
                        time_en, wakeup_enable, sleep_request, init_request};
  wire [7:0] ctl1_rd = {mode.module_enable, mode.clock_source_select, mode.loopback_self_test,
                        mode.listen_only, mode.busoff_recovery_mode, mode.wakeup_filter_mode,
                        sleep_acknowledge, init_acknowledge};
  wire [31:0] rd_mux = (idx == `CMC_IDX_CTL0) ? {24'h000000, ctl0_rd} :
                       (idx == `CMC_IDX_CTL1) ? {24'h000000, ctl1_rd} :
                       (idx == `CMC_IDX_AUX) ? {31'h00000000, recover_req} :
                       {16'h0000, ts_count};
  wire stamp_now = time_en && (tx_eof_valid || (rx_eof_valid && !mode.loopback_self_test));

  // ----------------------------------------------------------------
  // avalon slave: one wait cycle, then the transfer is taken
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h00000000;
    end else if (ce) begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
      if ((avs_read || avs_write) && avs_waitrequest) begin
        avs_readdata <= rd_mux;
      end
    end
  end

  // ----------------------------------------------------------------
  // control register zero
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      received_frame_flag <= 1'b0;
      receiver_active <= 1'b0;
      stop_in_wait <= 1'b0;
      time_en <= 1'b0;
      wakeup_enable <= 1'b0;
      sleep_request <= 1'b0;
      init_request <= 1'b1;
    end else if (ce) begin
      receiver_active <= rx_active_in && !init_request;
      if (init_mode) begin
        received_frame_flag <= 1'b0;
        stop_in_wait <= 1'b0;
        time_en <= 1'b0;
      end else begin
        if (rx_eof_valid && !mode.loopback_self_test) begin
          received_frame_flag <= 1'b1;
        end else if (wr_ctl0_run && wd[`CMC_C0_RECEIVED_FRAME_FLAG]) begin
          received_frame_flag <= 1'b0;
        end
        if (wr_ctl0_run) begin
          stop_in_wait <= wd[`CMC_C0_STOPWAIT];
          time_en <= wd[`CMC_C0_TIME];
        end
      end
      if (wr_ctl0_run) begin
        wakeup_enable <= wd[`CMC_C0_WAKEUP_ENABLE];
      end
      if (wake) begin
        sleep_request <= 1'b0;
      end else if (wr_ctl0_run && wd[`CMC_C0_SLEEP_REQUEST] && !wakeup_int_flag) begin
        sleep_request <= 1'b1;
      end else if (wr_ctl0_run && !wd[`CMC_C0_SLEEP_REQUEST] && sleep_acknowledge) begin
        sleep_request <= 1'b0;
      end
      if (wr_ctl0 && wd[`CMC_C0_INIT_REQUEST]) begin
        init_request <= 1'b1;
      end else if (wr_ctl0 && init_acknowledge) begin
        init_request <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // handshakes and control register one
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      init_acknowledge <= 1'b1;
      sleep_acknowledge <= 1'b0;
      mode <= cmc_pkg::cmc_mode_t'(6'b000100);
      enable_written <= 1'b0;
    end else if (ce) begin
      init_acknowledge <= init_request;
      if (wake || !sleep_request) begin
        sleep_acknowledge <= 1'b0;
      end else if (bus_idle && !init_request) begin
        sleep_acknowledge <= 1'b1;
      end
      if (wr_ctl1_init) begin
        mode.clock_source_select <= wd[`CMC_C1_CLOCK_SOURCE_SELECT];
        mode.loopback_self_test <= wd[`CMC_C1_LOOP];
        mode.listen_only <= wd[`CMC_C1_LISTEN];
        mode.busoff_recovery_mode <= wd[`CMC_C1_BUSOFF_RECOVERY_MODE];
        mode.wakeup_filter_mode <= wd[`CMC_C1_WAKEUP_FILTER_MODE];
        if (special_mode || !enable_written) begin
          mode.module_enable <= wd[`CMC_C1_ENABLE];
          enable_written <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // synchronisation and bus-off recovery
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      bus_synchronized <= 1'b0;
      busoff_recover <= 1'b0;
      recover_req <= 1'b0;
      engine_abort <= 1'b1;
    end else if (ce) begin
      engine_abort <= init_request;
      busoff_recover <= !init_request && busoff_in && idle_done && !busoff_recover
                        && (!mode.busoff_recovery_mode || recover_req);
      if (busoff_recover) begin
        recover_req <= 1'b0;
      end else if (wr_aux && wd[`CMC_AUX_RECOVER]) begin
        recover_req <= 1'b1;
      end
      if (init_request || busoff_in || !mode.module_enable) begin
        bus_synchronized <= 1'b0;
      end else if (idle_done) begin
        bus_synchronized <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // wakeup filter: dominant must last the filter time
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      wup_state <= cmc_pkg::CMC_WUP_IDLE;
      wup_cnt <= '0;
      wakeup_event <= 1'b0;
    end else if (ce) begin
      wakeup_event <= wake;
      unique case (wup_state)
        cmc_pkg::CMC_WUP_IDLE: begin
          wup_cnt <= '0;
          if (asleep && dominant) begin
            wup_state <= cmc_pkg::CMC_WUP_DOM;
          end
        end
        cmc_pkg::CMC_WUP_DOM: begin
          if (!asleep || !dominant) begin
            wup_state <= cmc_pkg::CMC_WUP_IDLE;
          end else if (32'(wup_cnt) < WUP_FILTER_CYC) begin
            wup_cnt <= wup_cnt + 1'b1;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // timestamp counter and buffer stamp
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      ts_count <= 16'h0000;
      stamp <= '0;
    end else if (ce) begin
      if (!time_en) begin
        ts_count <= 16'h0000;
      end else if (bit_tick) begin
        ts_count <= ts_count + 16'h0001;
      end
      stamp.write <= stamp_now;
      stamp.value <= ts_count;
    end
  end

  // ----------------------------------------------------------------
  // pins, loopback path and clock gate
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      bus_transmit_pin <= 1'b1;
      eng_rx_bit <= 1'b1;
      iface_clock_stop <= 1'b0;
    end else if (ce) begin
      bus_transmit_pin <= force_recessive ? 1'b1 : eng_tx_bit;
      eng_rx_bit <= mode.loopback_self_test ? eng_tx_bit : rx_s;
      iface_clock_stop <= cpu_wait && stop_in_wait;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_received_frame_flag_set;
    @(posedge mclk) disable iff (rst) (ce && rx_eof_valid && !mode.loopback_self_test && !init_mode)
      |=> received_frame_flag;
  endproperty
  a_received_frame_flag_set: assert property (p_received_frame_flag_set) else $error("frame flag not set");

  property p_receiver_active;
    @(posedge mclk) disable iff (rst) (ce && !init_request) |=> (receiver_active == $past(rx_active_in));
  endproperty
  a_receiver_active: assert property (p_receiver_active) else $error("receiver active wrong");

  property p_wait_recessive;
    @(posedge mclk) disable iff (rst) (ce && (cpu_stop || (cpu_wait && stop_in_wait))) |=> bus_transmit_pin;
  endproperty
  a_wait_recessive: assert property (p_wait_recessive) else $error("transmit not recessive");

  property p_sync_drop;
    @(posedge mclk) disable iff (rst) (ce && init_request) |=> !bus_synchronized;
  endproperty
  a_sync_drop: assert property (p_sync_drop) else $error("sync kept in init");

  property p_timer_clear;
    @(posedge mclk) disable iff (rst) (ce && !time_en) |=> (ts_count == 16'h0000);
  endproperty
  a_timer_clear: assert property (p_timer_clear) else $error("timer not cleared");

  property p_no_loop_stamp;
    @(posedge mclk) disable iff (rst) (ce && rx_eof_valid && !tx_eof_valid && mode.loopback_self_test)
      |=> !stamp.write;
  endproperty
  a_no_loop_stamp: assert property (p_no_loop_stamp) else $error("stamp in loopback");

  property p_sleep_idle;
    @(posedge mclk) disable iff (rst) $rose(sleep_acknowledge) |-> $past(bus_idle && sleep_request);
  endproperty
  a_sleep_idle: assert property (p_sleep_idle) else $error("sleep granted while busy");

  property p_loopback;
    @(posedge mclk) disable iff (rst) (ce && mode.loopback_self_test) |=> (eng_rx_bit == $past(eng_tx_bit))
      && bus_transmit_pin;
  endproperty
  a_loopback: assert property (p_loopback) else $error("loopback path wrong");

  property p_init_ack;
    @(posedge mclk) disable iff (rst) (ce && init_request && !init_acknowledge) |=> init_acknowledge;
  endproperty
  a_init_ack: assert property (p_init_ack) else $error("init not acknowledged");
endmodule
`default_nettype wire

/* File: sim/cmc_bus_model.sv */
// bus-side model: bit clock and receive line level of the can bus
`timescale 1ns/1ns
`default_nettype none
module cmc_bus_model (
  input wire logic mclk,        // module clock
  input wire logic rst,         // synchronous reset
  input wire logic dominant,    // bench asks for bus traffic
  output logic bus_receive_pin, // bus level, 1 recessive
  output logic bit_tick         // one pulse per bit time
);
  logic [1:0] div;
  // four clocks a bit; the line idles recessive so idle runs count up
  always_ff @(posedge mclk) begin
    div <= rst ? 2'h0 : div + 2'h1;
    bit_tick <= !rst && div == 2'h3;
    bus_receive_pin <= !dominant;
  end
endmodule
`default_nettype wire

/* File: sim/can_mode_control_tb.sv */
// self-checking bench of the mode control block
`timescale 1ns/1ns
`default_nettype none
module can_mode_control_tb;
  logic mclk = 0;
  logic rst = 1;
  logic avs_read = 0;
  logic avs_write = 0;
  logic [3:0] avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic rx_act = 0, rx_eof = 0, wint = 0, cwait = 0, spec = 0, txb = 0, dom = 0;
  logic txe = 1, cstop = 0, boff = 0, recd = 0;
  logic [1:0] woke = 0;
  logic wreq, txpin, rxbit, rpin, tick, abort, sync, recov, wev, clkstop;
  logic [31:0] rdata, rd;
  logic [7:0] d;
  logic [15:0] t1;
  int seed = 98716, error_cnt = 0, cmp_count = 0, cyc = 0;
  cmc_pkg::cmc_mode_t mode;
  cmc_pkg::cmc_stamp_t stamp;
  always #2 mclk = ~mclk;
  cmc_bus_model i_bus (.mclk(mclk), .rst(rst), .dominant(dom), .bus_receive_pin(rpin), .bit_tick(tick));
  cmc_mode_control #(.WUP_FILTER_CYC(4)) i_dut (.mclk(mclk), .rst(rst), .ce(1'b1), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(rd), .avs_waitrequest(wreq), .bus_receive_pin(rpin), .bus_transmit_pin(txpin),
    .eng_tx_bit(txb), .eng_rx_bit(rxbit), .bit_tick(tick), .rx_active_in(rx_act), .tx_buffers_empty(txe),
    .rx_eof_valid(rx_eof), .tx_eof_valid(1'b0), .busoff_in(boff), .wakeup_int_flag(wint), .cpu_wait(cwait),
    .cpu_stop(cstop), .special_mode(spec), .mode(mode), .stamp(stamp), .engine_abort(abort),
    .bus_synchronized(sync), .busoff_recover(recov), .wakeup_event(wev), .iface_clock_stop(clkstop));
  // expected control one read-back from written value and init acknowledge
  function automatic logic [15:0] c1_exp(input logic [7:0] v, input logic ak);
    return {8'h0, v[7:2], 1'b0, ak};
  endfunction
  // one avalon transfer, held until waitrequest is sampled low; only the cycle limit ends a hung wait
  task automatic acc(input logic wr, input logic [3:0] a, input logic [7:0] wd);
    @(posedge mclk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {24'h0, wd};
    @(posedge mclk);
    while (wreq !== 1'b0) begin
      @(posedge mclk);
    end
    rdata = rd;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // cycle limit (bus-off wait of 128 idle runs is about 5700 cycles), transmit stream, pulse capture
  always @(posedge mclk) begin
    cyc++;
    txb <= ~txb;
    if (wev === 1'b1) woke <= woke + 2'h1;
    if (recov === 1'b1) recd <= 1'b1;
    if (cyc == 8000) begin
      error_cnt++;
      tally_and_finish;
    end
  end
  initial begin
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    acc(0, 4'h0, 8'h0);
    chk(rdata[15:0], 16'h0001);
    acc(0, 4'h4, 8'h0);
    chk(rdata[15:0], 16'h0011);
    d = (8'($random(seed)) & 8'hd8) | 8'h80;
    acc(1, 4'h4, d);
    acc(0, 4'h4, 8'h0);
    chk(rdata[15:0], c1_exp(d, 1'b1));
    chk(16'(mode), 16'(d[7:2]));
    acc(1, 4'h4, d & 8'h7f);
    acc(0, 4'h4, 8'h0);
    chk(rdata[15:0], c1_exp(d, 1'b1));
    acc(1, 4'h0, 8'h00);
    repeat (80) @(posedge mclk);
    chk(16'(sync), 16'h1);
    acc(1, 4'h4, 8'h00);
    acc(0, 4'h4, 8'h0);
    chk(rdata[15:0], c1_exp(d, 1'b0));
    acc(1, 4'h0, 8'h08);
    acc(0, 4'hc, 8'h0);
    t1 = rdata[15:0];
    repeat (37) @(posedge mclk);
    acc(0, 4'hc, 8'h0);
    chk(rdata[15:0] - t1, 16'd10);
    @(posedge mclk) rx_eof <= 1'b1;
    @(posedge mclk) rx_eof <= 1'b0;
    #1 chk(16'(stamp.write), 16'h1);
    chk(16'(stamp.value > t1), 16'h1);
    acc(1, 4'h0, 8'h08);
    acc(0, 4'h0, 8'h0);
    chk(rdata[15:0] & 16'h98, 16'h98);
    acc(1, 4'h0, 8'h88);
    acc(0, 4'h0, 8'h0);
    chk(rdata[15:0] & 16'h88, 16'h08);
    acc(1, 4'h0, 8'h00);
    acc(0, 4'hc, 8'h0);
    chk(rdata[15:0], 16'h0);
    rx_act <= 1'b1;
    acc(0, 4'h0, 8'h0);
    chk(16'(rdata[6]), 16'h1);
    rx_act <= 1'b0;
    wint <= 1'b1;
    acc(1, 4'h0, 8'h06);
    acc(0, 4'h0, 8'h0);
    chk(16'(rdata[1]), 16'h0);
    wint <= 1'b0;
    txe <= 1'b0;
    acc(1, 4'h0, 8'h06);
    acc(0, 4'h4, 8'h0);
    chk(16'(rdata[1]), 16'h0);
    txe <= 1'b1;
    acc(0, 4'h4, 8'h0);
    chk(16'(rdata[1]), 16'h1);
    dom <= 1'b1;
    repeat (20) @(posedge mclk);
    dom <= 1'b0;
    acc(0, 4'h4, 8'h0);
    chk(16'({woke, rdata[1]}), 16'h2);
    acc(1, 4'h0, 8'h24);
    cwait <= 1'b1;
    repeat (3) @(posedge mclk);
    chk(16'({clkstop, txpin}), 16'h3);
    cwait <= 1'b0;
    cstop <= 1'b1;
    repeat (3) @(posedge mclk);
    chk(16'({clkstop, txpin}), 16'h1);
    @(posedge mclk) chk(16'(txpin), 16'h1);
    cstop <= 1'b0;
    acc(1, 4'h0, 8'h25);
    repeat (3) @(posedge mclk);
    chk(16'({abort, txpin, sync}), 16'h6);
    acc(0, 4'h0, 8'h0);
    chk(rdata[15:0], 16'h0005);
    spec <= 1'b1;
    boff <= 1'b1;
    acc(1, 4'h4, 8'h2c);
    acc(0, 4'h4, 8'h0);
    chk(rdata[15:0], c1_exp(8'h2c, 1'b1));
    #1 chk(16'({rxbit, txpin}), 16'({~txb, 1'b1}));
    acc(1, 4'h0, 8'h04);
    acc(1, 4'h8, 8'h01);
    acc(1, 4'h0, 8'h06);
    dom <= 1'b1;
    repeat (2) @(posedge mclk);
    dom <= 1'b0;
    repeat (8) @(posedge mclk);
    chk(16'(woke), 16'h1);
    dom <= 1'b1;
    repeat (20) @(posedge mclk);
    dom <= 1'b0;
    acc(0, 4'h4, 8'h0);
    chk(16'({woke, rdata[1]}), 16'h4);
    repeat (4800) @(posedge mclk);
    chk(16'({recd, sync}), 16'h0);
    repeat (1100) @(posedge mclk);
    chk(16'(recd), 16'h1);
    tally_and_finish;
  end
endmodule
`default_nettype wire
